// ==== sim/fbw_frag_src.sv ====
// Model of the fragment pipeline that feeds finished fragments to the write stage
`timescale 1ns/100ps
module fbw_frag_src import fbw_pkg::*; (
    input  wire logic       clk,
    input  wire logic       go,
    input  wire logic [3:0] gap,
    input  wire logic [1:0] idx_in,
    input  wire fbw_frag_t  frag_in,
    output logic            frag_valid,
    output logic [1:0]      frag_idx,
    output fbw_frag_t       frag
);
    logic       pend_reg  = 1'b0;
    logic [3:0] cnt_reg   = 4'h0;
    logic       valid_reg = 1'b0;
    logic [1:0] idx_reg   = 2'h0;
    fbw_frag_t  frag_reg  = '0;
    assign frag_valid = valid_reg;
    assign frag_idx   = idx_reg;
    assign frag       = frag_reg;
    // Fragment goes out for one cycle after gap+1 idle cycles
    always @(posedge clk) begin
        valid_reg <= 1'b0;
        if (go) begin
            pend_reg <= 1'b1;
            cnt_reg  <= gap;
        end else if (pend_reg && cnt_reg != 4'h0) begin
            cnt_reg <= cnt_reg - 4'h1;
        end else if (pend_reg) begin
            pend_reg  <= 1'b0;
            valid_reg <= 1'b1;
            idx_reg   <= idx_in;
            frag_reg  <= frag_in;
        end else begin
            // With no fragment pending the lines toggle every cycle; they hold during the gap countdown
            frag_reg <= ~frag_reg;
            idx_reg  <= ~idx_reg;
        end
    end
endmodule

// ==== sim/test_fbw_stage.sv ====
// Self-checking bench for the framebuffer write stage
`timescale 1ns/100ps
module test_fbw_stage import fbw_pkg::*; ;
    logic clk = 1'b0, rst_b = 1'b0, cmd_valid = 1'b0, index_mode = 1'b0, go = 1'b0;
    fbw_cmd_t cmd_op = FBW_CMD_NOP;
    logic [31:0] cmd_arg = 32'h0;
    logic [3:0] cmd_count = 4'h0, go_gap = 4'h0;
    logic [15:0] cmd_list = 16'h0;
    logic [1:0] cmd_face = 2'h0, go_idx = 2'h0, frag_idx, err_code;
    fbw_frag_t go_frag = '0, stored = '0, frag, wr_data, ff, ss, fb, fs, ms_data;
    logic frag_valid, err_pulse, wr_valid, wr_depth, wr_sten, wr_sample, wr_clear, wr_accum;
    logic ms_sample, ms_depth;
    logic [5:0] wr_surf;
    int n_mismatch = 0, n_compared = 0, cycles = 0;
    logic [5:0] single_exp [0:11] = '{6'h00, 6'h01, 6'h02, 6'h04, 6'h08, 6'h03,
                                      6'h0c, 6'h05, 6'h0a, 6'h0f, 6'h10, 6'h20};

    fbw_stage #(.HAS_RIGHT(1'b1)) fbw_stage_inst (
        .CLK(clk), .RST_B(rst_b), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_ARG(cmd_arg), .CMD_COUNT(cmd_count), .CMD_LIST(cmd_list),
        .CMD_FACE(cmd_face), .INDEX_MODE(index_mode), .FRAG_VALID(frag_valid),
        .FRAG_COLOR_IDX(frag_idx), .FRAG(frag), .STORED(stored), .ERR_CODE(err_code),
        .ERR_PULSE(err_pulse), .WR_VALID(wr_valid), .WR_SURF(wr_surf), .WR_DATA(wr_data),
        .WR_DEPTH(wr_depth), .WR_STEN(wr_sten), .WR_SAMPLE(wr_sample),
        .WR_CLEAR(wr_clear), .WR_ACCUM(wr_accum));
    // Same stage with multisample storage, fed the same stimulus
    fbw_stage #(.HAS_RIGHT(1'b1), .HAS_MS(1'b1)) fbw_stage_ms_inst (
        .CLK(clk), .RST_B(rst_b), .CMD_VALID(cmd_valid), .CMD_OP(cmd_op),
        .CMD_ARG(cmd_arg), .CMD_COUNT(cmd_count), .CMD_LIST(cmd_list),
        .CMD_FACE(cmd_face), .INDEX_MODE(index_mode), .FRAG_VALID(frag_valid),
        .FRAG_COLOR_IDX(frag_idx), .FRAG(frag), .STORED(stored), .ERR_CODE(),
        .ERR_PULSE(), .WR_VALID(), .WR_SURF(), .WR_DATA(ms_data),
        .WR_DEPTH(ms_depth), .WR_STEN(), .WR_SAMPLE(ms_sample),
        .WR_CLEAR(), .WR_ACCUM());
    fbw_frag_src fbw_frag_src_inst (
        .clk(clk), .go(go), .gap(go_gap), .idx_in(go_idx), .frag_in(go_frag),
        .frag_valid(frag_valid), .frag_idx(frag_idx), .frag(frag));

    always #25 clk = ~clk;

    task automatic end_of_test;
        $display("compared %0d mismatches %0d", n_compared, n_mismatch);
        if (n_mismatch == 0 && n_compared > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 4000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        n_compared++;
        if (got !== exp) begin
            n_mismatch++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmd(input fbw_cmd_t op, input logic [31:0] arg, input logic [1:0] face = 2'h0,
                       input logic [3:0] cnt = 4'h0, input logic [15:0] list = 16'h0);
        @(posedge clk);
        cmd_valid <= 1'b1;
        cmd_op <= op;
        cmd_arg <= arg;
        cmd_face <= face;
        cmd_count <= cnt;
        cmd_list <= list;
        @(posedge clk);
        cmd_valid <= 1'b0;
        #1;
    endtask

    // Fragment through the model; returns where the write beat is visible
    task automatic send(input logic [1:0] idx, input fbw_frag_t f, input logic [3:0] gap = 4'h0);
        int i;
        @(posedge clk);
        go <= 1'b1;
        go_gap <= gap;
        go_idx <= idx;
        go_frag <= f;
        stored <= ss;
        @(posedge clk);
        go <= 1'b0;
        #1;
        i = 0;
        while (frag_valid !== 1'b1 && i < 20) begin
            @(posedge clk);
            #1;
            i++;
        end
        @(posedge clk);
        #1;
    endtask

    task automatic surf(input logic [5:0] exp);
        if (exp == 6'h00) begin
            check({63'h0, wr_valid & (|wr_surf)}, 64'h0);
        end else begin
            check({57'h0, wr_valid, wr_surf}, {57'h0, 1'b1, exp});
        end
    endtask

    task automatic err(input logic p, input logic [1:0] code);
        if (p) begin
            check({err_pulse, err_code}, {1'b1, code});
        end else begin
            check(err_pulse, 1'b0);
        end
    endtask

    initial begin
        ff = '{color: 32'h44332211, depth: 16'h1234, stencil: 8'hab, back_face: 1'b0, sample: 1'b0};
        ss = '{color: 32'hddccbbaa, depth: 16'h0000, stencil: 8'h55, back_face: 1'b0, sample: 1'b0};
        fb = ff;
        fb.back_face = 1'b1;
        fs = ff;
        fs.sample = 1'b1;
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        send(2'h0, ff);
        surf(6'h0c);
        check({wr_depth, wr_sten, wr_data.depth, wr_data.stencil, wr_data.color},
              {2'h3, 16'h1234, 8'hab, 32'h44332211});
        send(2'h1, ff);
        surf(6'h00);
        cmd(FBW_CMD_CLEAR, 32'h7);
        check({wr_clear, wr_surf}, {1'b1, 6'h0c});
        check({wr_data.color, wr_data.depth, wr_data.stencil}, {32'h0, 16'hffff, 8'h0});
        check({wr_sample, ms_sample}, 2'h1);
        $display("test reset_state done");
        for (int k = 0; k < 12; k++) begin
            cmd(FBW_CMD_SINGLE, k);
            err(1'b0, ERR_NONE);
            send(2'h0, ff);
            surf(single_exp[k]);
        end
        $display("test single_select done");
        cmd(FBW_CMD_MULTI, 32'h0, 2'h0, 4'h4, 16'h4321);
        err(1'b0, ERR_NONE);
        send(2'h3, ff);
        surf(6'h08);
        cmd(FBW_CMD_SINGLE, 32'h1);
        send(2'h1, ff);
        surf(6'h00);
        cmd(FBW_CMD_MULTI, 32'h0, 2'h0, 4'h2, 16'h0000);
        err(1'b0, ERR_NONE);
        send(2'h0, ff);
        surf(6'h00);
        cmd(FBW_CMD_MULTI, 32'h0, 2'h0, 4'h3, 16'h014b);
        send(2'h0, ff);
        surf(6'h20);
        send(2'h2, ff, 4'h3);
        surf(6'h01);
        send(2'h3, ff);
        surf(6'h00);
        $display("test multi_select done");
        cmd(FBW_CMD_SINGLE, 32'hc);
        err(1'b1, ERR_OP);
        send(2'h0, ff);
        surf(6'h20);
        cmd(FBW_CMD_MULTI, 32'h0, 2'h0, 4'h2, 16'h0011);
        err(1'b1, ERR_OP);
        for (int c = 5; c < 10; c++) begin
            cmd(FBW_CMD_MULTI, 32'h0, 2'h0, 4'h1, c);
            err(1'b1, ERR_OP);
        end
        cmd(FBW_CMD_MULTI, 32'h0, 2'h0, 4'h5, 16'h0000);
        err(1'b1, ERR_VALUE);
        cmd(FBW_CMD_MULTI, 32'h0, 2'h0, 4'h4, 16'h000b);
        err(1'b0, ERR_NONE);
        cmd(FBW_CMD_CLEAR, 32'h10);
        err(1'b1, ERR_VALUE);
        check(wr_valid, 1'b0);
        $display("test errors done");
        cmd(FBW_CMD_SINGLE, 32'h6);
        cmd(FBW_CMD_COMPEN, 32'h5);
        send(2'h0, ff);
        check(wr_data.color, 32'hdd33bb11);
        check({wr_sample, ms_sample, ms_depth, ms_data.color}, {3'h0, 32'h44332211});
        send(2'h0, fs);
        check({wr_sample, ms_sample, ms_depth, ms_data.color}, {3'h3, 32'hdd33bb11});
        @(posedge clk);
        index_mode <= 1'b1;
        cmd(FBW_CMD_PALMASK, 32'h0f);
        send(2'h0, ff);
        check(wr_data.color[7:0], 8'ha1);
        @(posedge clk);
        index_mode <= 1'b0;
        cmd(FBW_CMD_ZEN, 32'h0);
        send(2'h0, ff);
        check({wr_valid, wr_depth}, 2'h2);
        cmd(FBW_CMD_CLEAR, 32'h2);
        check({wr_depth, ms_sample}, 2'h1);
        cmd(FBW_CMD_ZEN, 32'h2);
        send(2'h0, ff);
        check(wr_depth, 1'b1);
        cmd(FBW_CMD_STFACE, 32'h0f, FACE_FRONT);
        cmd(FBW_CMD_STFACE, 32'hf0, FACE_BACK);
        send(2'h0, ff);
        check(wr_data.stencil, 8'h5b);
        send(2'h0, fb);
        check(wr_data.stencil, 8'ha5);
        cmd(FBW_CMD_STCOM, 32'h3c);
        send(2'h0, fb);
        check(wr_data.stencil, 8'h69);
        cmd(FBW_CMD_STFACE, 32'h00, FACE_BACK);
        cmd(FBW_CMD_CLRVAL, 32'h1ab, 2'h3);
        cmd(FBW_CMD_CLEAR, 32'h4);
        check({wr_sten, wr_data.stencil}, {1'b1, 8'h69});
        cmd(FBW_CMD_CLEAR, 32'h8);
        check(wr_accum, 1'b1);
        cmd(FBW_CMD_CLEAR, 32'h1);
        check({wr_clear, wr_surf, ms_sample}, {1'b1, 6'h0c, 1'b1});
        cmd(FBW_CMD_SINGLE, 32'h0);
        cmd(FBW_CMD_CLEAR, 32'h1);
        surf(6'h00);
        check({wr_sample, ms_sample}, 2'h0);
        $display("test masks_clears done");
        end_of_test();
    end
endmodule

// ==== src/fbw_pkg.sv ====
// Package for the framebuffer write select, mask and clear stage
package fbw_pkg;
    localparam int FBW_SEL_W = 4;
    localparam logic [3:0] SEL_NONE   = 4'h0;
    localparam logic [3:0] SEL_FL     = 4'h1;
    localparam logic [3:0] SEL_FR     = 4'h2;
    localparam logic [3:0] SEL_BL     = 4'h3;
    localparam logic [3:0] SEL_BR     = 4'h4;
    localparam logic [3:0] SEL_FRONT  = 4'h5;
    localparam logic [3:0] SEL_BACK   = 4'h6;
    localparam logic [3:0] SEL_LEFT   = 4'h7;
    localparam logic [3:0] SEL_RIGHT  = 4'h8;
    localparam logic [3:0] SEL_FAB    = 4'h9;
    localparam logic [3:0] SEL_FIRST_AUXILIARY_SURFACE   = 4'ha;
    localparam int SURF_FL  = 0;
    localparam int SURF_FR  = 1;
    localparam int SURF_BL  = 2;
    localparam int SURF_BR  = 3;
    localparam int SURF_AUX = 4;
    localparam logic [3:0] CLR_COLOR = 4'h1;
    localparam logic [3:0] CLR_DEPTH = 4'h2;
    localparam logic [3:0] CLR_STEN  = 4'h4;
    localparam logic [3:0] CLR_ACCUM = 4'h8;
    localparam logic [15:0] DEPTH_ONE = 16'hffff;
    localparam logic [1:0] FACE_FRONT = 2'h1;
    localparam logic [1:0] FACE_BACK  = 2'h2;
    localparam logic [1:0] ERR_NONE   = 2'h0;
    localparam logic [1:0] ERR_OP     = 2'h1;
    localparam logic [1:0] ERR_VALUE  = 2'h2;
    typedef enum logic [3:0] {
        FBW_CMD_NOP     = 4'h0,
        FBW_CMD_SINGLE  = 4'h1,
        FBW_CMD_MULTI   = 4'h2,
        FBW_CMD_PALMASK = 4'h3,
        FBW_CMD_COMPEN  = 4'h4,
        FBW_CMD_ZEN     = 4'h5,
        FBW_CMD_STCOM   = 4'h6,
        FBW_CMD_STFACE  = 4'h7,
        FBW_CMD_CLRVAL  = 4'h8,
        FBW_CMD_CLEAR   = 4'h9
    } fbw_cmd_t;
    typedef struct packed {
        logic [31:0] color;
        logic [15:0] depth;
        logic [7:0]  stencil;
        logic        back_face;
        logic        sample;
    } fbw_frag_t;
endpackage

// ==== src/fbw_stage.sv ====
// Framebuffer write stage: surface select, write masks and clears
`timescale 1ns/100ps
// Functional notes
// - Single-target command sets surface set of colour zero: 0,1,2,4 or aux
// - Missing side means left and right; missing position means front and back
// - Aux selector enables only aux surface i, code is first aux plus i
// - Selector naming no allocated surface flags bad operation
// - Single-target command sets all other colours to no target
// - Multi-target list fills colours upward, rest set to no target
// - Repeated surface in list flags bad operation; repeated no target allowed
// - Multi-surface selector in list flags bad operation
// - List count above limit flags bad value; limit at least one
// - Colour with no target writes no surface
// - Reset: colour zero selects back if present else front; others none
// - Index bits gated by palette mask; RGBA by component enables
// - Depth written only while z write enable set
// - Separate front and back stencil masks; per-face and common commands
// - Face picks stencil mask; clears use front mask
// - Reset: index and stencil masks ones, depth and colour enables set
// - With multisample, colour masks gate samples only; resolved colour ignores them
// - Clear flags colour, depth, stencil, accum; other bits flag bad value
// - Clears use write masks; clear of missing buffer has no effect
// - Stencil clear value masked to planes; index clear masked to 2^m-1
// - Reset clear values zero, depth clear value one
// - Colour clear hits samples unless colour zero selects none; depth, stencil too
module fbw_stage import fbw_pkg::*; #(
    parameter int  NCOL     = 4,
    parameter int  NAUX     = 2,
    parameter int  SBITS    = 8,
    parameter int  IBITS    = 8,
    parameter bit  HAS_BACK = 1'b1,
    parameter bit  HAS_RIGHT = 1'b0,
    parameter bit  HAS_DEPTH = 1'b1,
    parameter bit  HAS_STEN = 1'b1,
    parameter bit  HAS_ACCUM = 1'b1,
    parameter bit  HAS_MS   = 1'b0
) (
    input  wire logic              CLK,
    input  wire logic              RST_B,
    input  wire logic              CMD_VALID,
    input  wire fbw_cmd_t          CMD_OP,
    input  wire logic [31:0]       CMD_ARG,
    input  wire logic [3:0]        CMD_COUNT,
    input  wire logic [NCOL*4-1:0] CMD_LIST,
    input  wire logic [1:0]        CMD_FACE,
    input  wire logic              INDEX_MODE,
    input  wire logic              FRAG_VALID,
    input  wire logic [1:0]        FRAG_COLOR_IDX,
    input  wire fbw_frag_t         FRAG,
    input  wire fbw_frag_t         STORED,
    output logic [1:0]             ERR_CODE,
    output logic                   ERR_PULSE,
    output logic                   WR_VALID,
    output logic [4+NAUX-1:0]      WR_SURF,
    output fbw_frag_t              WR_DATA,
    output logic                   WR_DEPTH,
    output logic                   WR_STEN,
    output logic                   WR_SAMPLE,
    output logic                   WR_CLEAR,
    output logic                   WR_ACCUM
);
    localparam int SW = 4 + NAUX;

    // Elaboration-time refusal of sizes the selector codes and data fields cannot carry
    if (NCOL < 1 || NCOL > 4 || NAUX < 0 || NAUX > 6 || SBITS < 1 || SBITS > 8
        || IBITS < 1 || IBITS > 32) begin
        $error("fbw_stage: parameter out of range");
    end

    logic [3:0]  sel_reg [NCOL];
    logic [IBITS-1:0] pal_mask_reg;
    logic [3:0]  comp_en_reg;
    logic        z_en_reg;
    logic [SBITS-1:0] st_front_reg;
    logic [SBITS-1:0] st_back_reg;
    logic [31:0] clr_color_reg;
    logic [31:0] clr_index_reg;
    logic [15:0] clr_depth_reg;
    logic [SBITS-1:0] clr_sten_reg;

    // Surfaces named by a selector
    function automatic logic [SW-1:0] surf_of(input logic [3:0] s);
        logic [SW-1:0] m;
        m = '0;
        unique case (s)
            SEL_FL:    m[SURF_FL] = 1'b1;
            SEL_FR:    m[SURF_FR] = 1'b1;
            SEL_BL:    m[SURF_BL] = 1'b1;
            SEL_BR:    m[SURF_BR] = 1'b1;
            SEL_FRONT: m[SURF_FR:SURF_FL] = 2'h3;
            SEL_BACK:  m[SURF_BR:SURF_BL] = 2'h3;
            SEL_LEFT:  begin m[SURF_FL] = 1'b1; m[SURF_BL] = 1'b1; end
            SEL_RIGHT: begin m[SURF_FR] = 1'b1; m[SURF_BR] = 1'b1; end
            SEL_FAB:   m[SURF_BR:SURF_FL] = 4'hf;
            default: begin
                if (s >= SEL_FIRST_AUXILIARY_SURFACE && int'(s - SEL_FIRST_AUXILIARY_SURFACE) < NAUX) begin
                    m[SURF_AUX + int'(s - SEL_FIRST_AUXILIARY_SURFACE)] = 1'b1;
                end
            end
        endcase
        return m;
    endfunction

    // Surfaces present in this context
    function automatic logic [SW-1:0] alloc_mask();
        logic [SW-1:0] m;
        m = '1;
        m[SURF_FR] = HAS_RIGHT;
        m[SURF_BL] = HAS_BACK;
        m[SURF_BR] = HAS_BACK & HAS_RIGHT;
        return m;
    endfunction

    // Selector valid: none or names an allocated surface
    function automatic logic sel_ok(input logic [3:0] s);
        return (s == SEL_NONE) || ((surf_of(s) & alloc_mask()) != '0);
    endfunction

    logic [1:0] multi_err;
    always_comb begin
        logic [SW-1:0] seen;
        logic [SW-1:0] sm;
        sm = '0;
        seen = '0;
        multi_err = ERR_NONE;
        if (int'(CMD_COUNT) > NCOL) begin
            multi_err = ERR_VALUE;
        end else begin
            for (int i = 0; i < NCOL; i++) begin
                if (i < int'(CMD_COUNT)) begin
                    sm = surf_of(CMD_LIST[i*4 +: 4]);
                    if (CMD_LIST[i*4 +: 4] >= SEL_FRONT && CMD_LIST[i*4 +: 4] <= SEL_FAB) begin
                        multi_err = ERR_OP;
                    end
                    if (!sel_ok(CMD_LIST[i*4 +: 4]) || (seen & sm) != '0) begin
                        multi_err = ERR_OP;
                    end
                    seen = seen | sm;
                end
            end
        end
    end

    logic single_bad;
    assign single_bad = !sel_ok(CMD_ARG[3:0]) || CMD_ARG[31:4] != '0;

    logic clear_bad;
    assign clear_bad = (CMD_ARG[31:4] != '0);

    // Selection state
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            for (int i = 0; i < NCOL; i++) begin
                sel_reg[i] <= SEL_NONE;
            end
            sel_reg[0] <= HAS_BACK ? SEL_BACK : SEL_FRONT;
        end else if (CMD_VALID && CMD_OP == FBW_CMD_SINGLE && !single_bad) begin
            for (int i = 0; i < NCOL; i++) begin
                sel_reg[i] <= SEL_NONE;
            end
            sel_reg[0] <= CMD_ARG[3:0];
        end else if (CMD_VALID && CMD_OP == FBW_CMD_MULTI && multi_err == ERR_NONE) begin
            for (int i = 0; i < NCOL; i++) begin
                sel_reg[i] <= (i < int'(CMD_COUNT)) ? CMD_LIST[i*4 +: 4] : SEL_NONE;
            end
        end
    end

    // Mask state
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            pal_mask_reg <= '1;
            comp_en_reg  <= 4'hf;
            z_en_reg     <= 1'b1;
            st_front_reg <= '1;
            st_back_reg  <= '1;
        end else if (CMD_VALID) begin
            unique case (CMD_OP)
                FBW_CMD_PALMASK: pal_mask_reg <= CMD_ARG[IBITS-1:0];
                FBW_CMD_COMPEN:  comp_en_reg  <= CMD_ARG[3:0];
                FBW_CMD_ZEN:     z_en_reg     <= (CMD_ARG != '0);
                FBW_CMD_STCOM: begin
                    st_front_reg <= CMD_ARG[SBITS-1:0];
                    st_back_reg  <= CMD_ARG[SBITS-1:0];
                end
                FBW_CMD_STFACE: begin
                    if (CMD_FACE[0]) st_front_reg <= CMD_ARG[SBITS-1:0];
                    if (CMD_FACE[1]) st_back_reg  <= CMD_ARG[SBITS-1:0];
                end
                default: ;
            endcase
        end
    end

    // Clear values; CMD_FACE picks which value CLRVAL loads
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            clr_color_reg <= '0;
            clr_index_reg <= '0;
            clr_depth_reg <= DEPTH_ONE;
            clr_sten_reg  <= '0;
        end else if (CMD_VALID && CMD_OP == FBW_CMD_CLRVAL) begin
            unique case (CMD_FACE)
                2'h0: clr_color_reg <= CMD_ARG;
                2'h1: clr_index_reg <= CMD_ARG & ((32'h1 << IBITS) - 32'h1);
                2'h2: clr_depth_reg <= CMD_ARG[15:0];
                2'h3: clr_sten_reg  <= CMD_ARG[SBITS-1:0];
            endcase
        end
    end

    // Error report
    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            ERR_CODE  <= ERR_NONE;
            ERR_PULSE <= 1'b0;
        end else begin
            ERR_PULSE <= 1'b0;
            if (CMD_VALID && CMD_OP == FBW_CMD_SINGLE && single_bad) begin
                ERR_CODE <= ERR_OP;
                ERR_PULSE <= 1'b1;
            end else if (CMD_VALID && CMD_OP == FBW_CMD_MULTI && multi_err != ERR_NONE) begin
                ERR_CODE <= multi_err;
                ERR_PULSE <= 1'b1;
            end else if (CMD_VALID && CMD_OP == FBW_CMD_CLEAR && clear_bad) begin
                ERR_CODE <= ERR_VALUE;
                ERR_PULSE <= 1'b1;
            end
        end
    end

    // Write path
    logic        is_clear;
    logic [3:0]  cur_sel;
    logic [31:0] cmask;
    logic [SBITS-1:0] smask;
    logic [31:0] nclr;
    always_comb begin
        is_clear = CMD_VALID && CMD_OP == FBW_CMD_CLEAR && !clear_bad;
        cur_sel  = is_clear ? sel_reg[0] : sel_reg[FRAG_COLOR_IDX];
        if (INDEX_MODE) begin
            cmask = '0;
            cmask[IBITS-1:0] = pal_mask_reg;
        end else begin
            for (int c = 0; c < 4; c++) begin
                cmask[c*8 +: 8] = {8{comp_en_reg[c]}};
            end
        end
        smask = (is_clear || !FRAG.back_face) ? st_front_reg : st_back_reg;
        nclr  = INDEX_MODE ? clr_index_reg : clr_color_reg;
    end

    always_ff @(posedge CLK) begin
        if (!RST_B) begin
            WR_VALID  <= 1'b0;
            WR_SURF   <= '0;
            WR_DATA   <= '0;
            WR_DEPTH  <= 1'b0;
            WR_STEN   <= 1'b0;
            WR_SAMPLE <= 1'b0;
            WR_CLEAR  <= 1'b0;
            WR_ACCUM  <= 1'b0;
        end else if (is_clear) begin
            WR_VALID  <= 1'b1;
            WR_CLEAR  <= 1'b1;
            WR_SURF   <= CMD_ARG[0] ? (surf_of(cur_sel) & alloc_mask()) : '0;
            WR_DATA.color   <= (nclr & cmask) | (STORED.color & ~cmask);
            WR_DATA.depth   <= clr_depth_reg;
            WR_DATA.stencil <= 8'((clr_sten_reg & smask) | (STORED.stencil[SBITS-1:0] & ~smask));
            WR_DATA.back_face <= 1'b0;
            WR_DATA.sample  <= 1'b0;
            WR_DEPTH  <= CMD_ARG[1] && HAS_DEPTH && z_en_reg;
            WR_STEN   <= CMD_ARG[2] && HAS_STEN;
            WR_ACCUM  <= CMD_ARG[3] && HAS_ACCUM;
            WR_SAMPLE <= HAS_MS && ((CMD_ARG[0] && sel_reg[0] != SEL_NONE)
                         || CMD_ARG[1] || CMD_ARG[2]);
        end else if (FRAG_VALID) begin
            WR_VALID  <= 1'b1;
            WR_CLEAR  <= 1'b0;
            WR_ACCUM  <= 1'b0;
            WR_SAMPLE <= HAS_MS && FRAG.sample;
            WR_SURF   <= surf_of(cur_sel) & alloc_mask();
            WR_DATA.back_face <= FRAG.back_face;
            WR_DATA.sample    <= FRAG.sample;
            WR_DATA.depth     <= FRAG.depth;
            if (HAS_MS && !FRAG.sample) begin
                WR_DATA.color <= FRAG.color;
            end else begin
                WR_DATA.color <= (FRAG.color & cmask) | (STORED.color & ~cmask);
            end
            WR_DATA.stencil <= 8'((FRAG.stencil[SBITS-1:0] & smask)
                               | (STORED.stencil[SBITS-1:0] & ~smask));
            WR_DEPTH  <= z_en_reg && (!HAS_MS || FRAG.sample);
            WR_STEN   <= 1'b1;
        end else begin
            WR_VALID  <= 1'b0;
            WR_CLEAR  <= 1'b0;
            WR_DEPTH  <= 1'b0;
            WR_STEN   <= 1'b0;
            WR_ACCUM  <= 1'b0;
            WR_SAMPLE <= 1'b0;
        end
    end

    chk_none_no_surf: assert property (@(posedge CLK) disable iff (!RST_B)
        FRAG_VALID && !is_clear && sel_reg[FRAG_COLOR_IDX] == SEL_NONE |=> WR_SURF == '0)
        else $error("no-target colour wrote a surface");
    chk_single_clears: assert property (@(posedge CLK) disable iff (!RST_B)
        CMD_VALID && CMD_OP == FBW_CMD_SINGLE && !single_bad && NCOL > 1
        |=> sel_reg[NCOL-1] == SEL_NONE)
        else $error("single select left other colour set");
    chk_single_err: assert property (@(posedge CLK) disable iff (!RST_B)
        CMD_VALID && CMD_OP == FBW_CMD_SINGLE && single_bad
        |=> ERR_PULSE && ERR_CODE == ERR_OP && $stable(sel_reg[0]))
        else $error("bad single selector not flagged");
    chk_count_limit: assert property (@(posedge CLK) disable iff (!RST_B)
        CMD_VALID && CMD_OP == FBW_CMD_MULTI && int'(CMD_COUNT) > NCOL
        |=> ERR_PULSE && ERR_CODE == ERR_VALUE)
        else $error("list count over limit not flagged");
    chk_clear_bits: assert property (@(posedge CLK) disable iff (!RST_B)
        CMD_VALID && CMD_OP == FBW_CMD_CLEAR && CMD_ARG[31:4] != '0
        |=> ERR_CODE == ERR_VALUE && !WR_CLEAR)
        else $error("bad clear flags not flagged");
    chk_depth_gate: assert property (@(posedge CLK) disable iff (!RST_B)
        !z_en_reg && !(CMD_VALID && CMD_OP == FBW_CMD_ZEN) |=> !WR_DEPTH)
        else $error("depth written while disabled");
    chk_face_mask: assert property (@(posedge CLK) disable iff (!RST_B)
        CMD_VALID && CMD_OP == FBW_CMD_STFACE && CMD_FACE == FACE_BACK
        |=> $stable(st_front_reg))
        else $error("back-face mask command changed front mask");
    chk_reset_vals: assert property (@(posedge CLK)
        RST_B && $past(!RST_B) |-> clr_depth_reg == DEPTH_ONE && z_en_reg && comp_en_reg == 4'hf
            && pal_mask_reg == '1 && st_front_reg == '1 && st_back_reg == '1)
        else $error("reset values wrong");
    chk_stencil_merge: assert property (@(posedge CLK) disable iff (!RST_B)
        FRAG_VALID && !is_clear && !FRAG.back_face
        |=> WR_DATA.stencil[SBITS-1:0] == (($past(FRAG.stencil[SBITS-1:0]) & $past(st_front_reg))
            | ($past(STORED.stencil[SBITS-1:0]) & ~$past(st_front_reg))))
        else $error("front stencil merge wrong");
endmodule
